// ---- logic/i2c_abort_pkg.sv ----
`default_nettype none
package i2c_abort_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] TARGET_OFS    = 8'h04;
	localparam logic [7:0] TXDATA_OFS    = 8'h08;
	localparam logic [7:0] ABORT_SRC_OFS = 8'h0C;
	localparam logic [7:0] ABORT_CLR_OFS = 8'h10;
	localparam logic [7:0] INT_STAT_OFS  = 8'h14;
	localparam logic [7:0] INT_EN_OFS    = 8'h18;
	localparam logic [7:0] INT_CLR_OFS   = 8'h1C;
	localparam logic [7:0] STATUS_OFS    = 8'h20;
	// Field positions
	localparam int CTRL_MASTER_EN_BIT = 0;
	localparam int CTRL_HS_BIT        = 2;
	localparam int CTRL_RESTART_BIT   = 5;
	localparam int TGT_GC_START_BIT   = 10;
	localparam int TGT_CMD_SEL_BIT    = 11;
	localparam int ABRT_HS_BIT        = 8;
	localparam int ABRT_SBYTE_BIT     = 9;
	localparam int INT_ABORT_BIT      = 0;
	localparam int INT_DONE_BIT       = 1;
	localparam int INT_NACK_BIT       = 2;
	localparam int INT_W              = 3;
	// Bus bytes and AXI response codes
	localparam logic [7:0] START_BYTE = 8'h01;
	localparam logic [7:0] GCALL_BYTE = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing: quarter of one bus bit
	localparam int CLK_NS          = 10;
	localparam int STD_QUARTER_NS  = 2500;
	localparam int HS_QUARTER_NS   = 80;
	localparam int STD_QUARTER_CYC = STD_QUARTER_NS / CLK_NS;
	localparam int HS_QUARTER_CYC  = HS_QUARTER_NS / CLK_NS;

	typedef struct packed {
		logic masterEn;
		logic hsMode;
		logic restartEn;
	} ctrl_t;

	typedef struct packed {
		logic       cmdSel;
		logic       gcStart;
		logic [9:0] addr;
	} target_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BIT   = 3'b010,
		ST_ACK   = 3'b011,
		ST_STOP  = 3'b100
	} bus_state_t;

	typedef struct packed {
		ctrl_t            ctrl;
		target_t          tgt;
		logic [7:0]       txByte;
		logic             cmdPend;
		logic             abrtSbyte;
		logic             abrtHs;
		logic             heldSbyte;
		logic             heldHs;
		logic [INT_W-1:0] intStat;
		logic [INT_W-1:0] intEn;
		bus_state_t       busState;
		logic [1:0]       quarter;
		logic [2:0]       bitIdx;
		logic [7:0]       shift;
		logic             firstByte;
		logic             nack;
		logic [11:0]      divCnt;
		logic             sclLow;
		logic             sdaLow;
		logic             sclMeta;
		logic             sclSync;
		logic             sdaMeta;
		logic             sdaSync;
		logic             awHeld;
		logic [7:0]       awAddr;
		logic             wHeld;
		logic [31:0]      wData;
		logic [3:0]       wStrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} state_t;

	localparam ctrl_t CTRL_RST = '{masterEn: 1'b1, hsMode: 1'b0, restartEn: 1'b1};
	localparam state_t STATE_RST = '{ctrl: CTRL_RST, sclMeta: 1'b1, sclSync: 1'b1,
		sdaMeta: 1'b1, sdaSync: 1'b1, busState: ST_IDLE, default: '0};
endpackage
`default_nettype wire

// ---- logic/restart_disabled_abort_flags.sv ----
// Operation
// - START byte without restart sets bit 9
// - Clear under live cause: low one cycle
// - Fixed cause: normal clear, stays clear
// - High-speed without restart sets bit 8
// - Flags read-only, reset zero, 1=occurred
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module restart_disabled_abort_flags #(
	parameter int STD_QUARTER = i2c_abort_pkg::STD_QUARTER_CYC,
	parameter int HS_QUARTER  = i2c_abort_pkg::HS_QUARTER_CYC
) (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// I2C pins, open drain
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOeN,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	// Interrupt
	output logic             irq
);
	i2c_abort_pkg::state_t s_q;
	i2c_abort_pkg::state_t s_d;
	logic                  rstMeta_q;
	logic                  rstSync_q;

	// Register read mux: {ok, data}
	function automatic logic [32:0] regRead(input logic [7:0] a, input i2c_abort_pkg::state_t st);
		logic [31:0] v;
		logic        ok;
		v = '0;
		ok = 1'b1;
		unique case (a)
			i2c_abort_pkg::CTRL_OFS: begin
				v[i2c_abort_pkg::CTRL_MASTER_EN_BIT] = st.ctrl.masterEn;
				v[i2c_abort_pkg::CTRL_HS_BIT] = st.ctrl.hsMode;
				v[i2c_abort_pkg::CTRL_RESTART_BIT] = st.ctrl.restartEn;
			end
			i2c_abort_pkg::TARGET_OFS: begin
				v[9:0] = st.tgt.addr;
				v[i2c_abort_pkg::TGT_GC_START_BIT] = st.tgt.gcStart;
				v[i2c_abort_pkg::TGT_CMD_SEL_BIT] = st.tgt.cmdSel;
			end
			i2c_abort_pkg::TXDATA_OFS: v[7:0] = st.txByte;
			i2c_abort_pkg::ABORT_SRC_OFS: begin
				v[i2c_abort_pkg::ABRT_SBYTE_BIT] = st.abrtSbyte;
				v[i2c_abort_pkg::ABRT_HS_BIT] = st.abrtHs;
			end
			i2c_abort_pkg::INT_STAT_OFS: v[i2c_abort_pkg::INT_W-1:0] = st.intStat;
			i2c_abort_pkg::INT_EN_OFS: v[i2c_abort_pkg::INT_W-1:0] = st.intEn;
			i2c_abort_pkg::ABORT_CLR_OFS, i2c_abort_pkg::INT_CLR_OFS: v = '0;
			i2c_abort_pkg::STATUS_OFS: begin
				v[0] = (st.busState != i2c_abort_pkg::ST_IDLE);
				v[1] = st.cmdPend;
				v[2] = st.nack;
			end
			default: ok = 1'b0;
		endcase
		return {ok, v};
	endfunction

	// Byte-lane merge
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Reset release synchroniser
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	assign awready = !s_q.awHeld && !s_q.bvalid;
	assign wready  = !s_q.wHeld && !s_q.bvalid;
	assign arready = !s_q.rvalid;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;
	assign sclOut  = 1'b0;
	assign sdaOut  = 1'b0;
	assign sclOeN  = !s_q.sclLow;
	assign sdaOeN  = !s_q.sdaLow;
	assign irq     = |(s_q.intStat & s_q.intEn);

	always_comb begin
		logic [32:0]                   rr;
		logic [32:0]                   wr;
		logic [31:0]                   wv;
		logic                          clrAbort;
		logic [i2c_abort_pkg::INT_W-1:0] intClr;
		logic [i2c_abort_pkg::INT_W-1:0] ev;
		logic                          causeS;
		logic                          causeH;
		logic                          reqTake;
		logic                          tick;
		logic [7:0]                    firstB;
		rr = '0;
		wr = '0;
		wv = '0;
		clrAbort = 1'b0;
		intClr = '0;
		ev = '0;
		firstB = '0;
		causeS = 1'b0;
		causeH = 1'b0;
		reqTake = 1'b0;
		tick = 1'b0;
		s_d = s_q;

		// Pin synchronisers
		s_d.sclMeta = sclIn;
		s_d.sclSync = s_q.sclMeta;
		s_d.sdaMeta = sdaIn;
		s_d.sdaSync = s_q.sdaMeta;

		// Write channel capture, either order
		if (awvalid && awready) begin
			s_d.awHeld = 1'b1;
			s_d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			s_d.wHeld = 1'b1;
			s_d.wData = wdata;
			s_d.wStrb = wstrb;
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.awHeld && s_q.wHeld && !s_q.bvalid) begin
			wr = regRead(s_q.awAddr, s_q);
			wv = laneMerge(wr[31:0], s_q.wData, s_q.wStrb);
			s_d.awHeld = 1'b0;
			s_d.wHeld = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr[32] ? i2c_abort_pkg::RESP_OKAY : i2c_abort_pkg::RESP_SLVERR;
			unique case (s_q.awAddr)
				i2c_abort_pkg::CTRL_OFS: begin
					s_d.ctrl.masterEn = wv[i2c_abort_pkg::CTRL_MASTER_EN_BIT];
					s_d.ctrl.hsMode = wv[i2c_abort_pkg::CTRL_HS_BIT];
					s_d.ctrl.restartEn = wv[i2c_abort_pkg::CTRL_RESTART_BIT];
				end
				i2c_abort_pkg::TARGET_OFS: begin
					s_d.tgt.addr = wv[9:0];
					s_d.tgt.gcStart = wv[i2c_abort_pkg::TGT_GC_START_BIT];
					s_d.tgt.cmdSel = wv[i2c_abort_pkg::TGT_CMD_SEL_BIT];
				end
				i2c_abort_pkg::TXDATA_OFS: begin
					if (s_q.wStrb[0]) begin
						s_d.txByte = wv[7:0];
						s_d.cmdPend = 1'b1;
					end
				end
				i2c_abort_pkg::ABORT_CLR_OFS: clrAbort = s_q.wStrb[0] && s_q.wData[0];
				i2c_abort_pkg::INT_EN_OFS: s_d.intEn = wv[i2c_abort_pkg::INT_W-1:0];
				i2c_abort_pkg::INT_CLR_OFS: intClr = s_q.wData[i2c_abort_pkg::INT_W-1:0];
				default: ;
			endcase
		end

		// Read channel
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			rr = regRead(araddr, s_q);
			s_d.rvalid = 1'b1;
			s_d.rdata = rr[31:0];
			s_d.rresp = rr[32] ? i2c_abort_pkg::RESP_OKAY : i2c_abort_pkg::RESP_SLVERR;
		end

		// Abort causes while repeated start is off
		causeS = !s_q.ctrl.restartEn && s_q.tgt.cmdSel && s_q.tgt.gcStart;
		causeH = !s_q.ctrl.restartEn && s_q.ctrl.hsMode;
		reqTake = (s_q.busState == i2c_abort_pkg::ST_IDLE) && s_q.cmdPend && s_q.ctrl.masterEn;
		s_d.abrtSbyte = (s_q.abrtSbyte && !clrAbort) || (reqTake && causeS)
			|| (s_q.heldSbyte && causeS && !clrAbort);
		s_d.abrtHs = (s_q.abrtHs && !clrAbort) || (reqTake && causeH)
			|| (s_q.heldHs && causeH && !clrAbort);
		// Held cause drops once software fixes it
		s_d.heldSbyte = causeS && (s_q.heldSbyte || reqTake);
		s_d.heldHs = causeH && (s_q.heldHs || reqTake);

		// Quarter-bit divider
		tick = (s_q.divCnt == '0);
		if (s_q.busState != i2c_abort_pkg::ST_IDLE) begin
			if (tick) begin
				s_d.divCnt = s_q.ctrl.hsMode ? 12'(HS_QUARTER - 1) : 12'(STD_QUARTER - 1);
			end else begin
				s_d.divCnt = s_q.divCnt - 12'h001;
			end
		end

		// Bus sequencer
		if (s_q.tgt.cmdSel) begin
			firstB = s_q.tgt.gcStart ? i2c_abort_pkg::START_BYTE : i2c_abort_pkg::GCALL_BYTE;
		end else begin
			firstB = {s_q.tgt.addr[6:0], 1'b0};
		end
		unique case (s_q.busState)
			i2c_abort_pkg::ST_IDLE: begin
				s_d.sclLow = 1'b0;
				s_d.sdaLow = 1'b0;
				if (reqTake) begin
					s_d.cmdPend = 1'b0;
					if (causeS || causeH) begin
						ev[i2c_abort_pkg::INT_ABORT_BIT] = 1'b1;
					end else begin
						s_d.busState = i2c_abort_pkg::ST_START;
						s_d.sdaLow = 1'b1;
						s_d.nack = 1'b0;
						s_d.divCnt = s_q.ctrl.hsMode ? 12'(HS_QUARTER - 1) : 12'(STD_QUARTER - 1);
					end
				end
			end
			i2c_abort_pkg::ST_START: begin
				if (tick) begin
					s_d.busState = i2c_abort_pkg::ST_BIT;
					s_d.sclLow = 1'b1;
					s_d.quarter = 2'h0;
					s_d.bitIdx = 3'h7;
					s_d.shift = firstB;
					s_d.firstByte = 1'b1;
					s_d.sdaLow = !firstB[7];
				end
			end
			i2c_abort_pkg::ST_BIT: begin
				if (tick) begin
					s_d.quarter = s_q.quarter + 2'h1;
					unique case (s_q.quarter)
						2'h0: s_d.sclLow = 1'b0;
						2'h1: ;
						2'h2: s_d.sclLow = 1'b1;
						2'h3: begin
							if (s_q.bitIdx == 3'h0) begin
								s_d.busState = i2c_abort_pkg::ST_ACK;
								s_d.sdaLow = 1'b0;
							end else begin
								s_d.bitIdx = s_q.bitIdx - 3'h1;
								s_d.sdaLow = !s_q.shift[s_q.bitIdx - 3'h1];
							end
						end
					endcase
				end
			end
			i2c_abort_pkg::ST_ACK: begin
				if (tick) begin
					s_d.quarter = s_q.quarter + 2'h1;
					unique case (s_q.quarter)
						2'h0: s_d.sclLow = 1'b0;
						2'h1: s_d.nack = s_q.sdaSync;
						2'h2: s_d.sclLow = 1'b1;
						2'h3: begin
							if (s_q.nack || !s_q.firstByte) begin
								s_d.busState = i2c_abort_pkg::ST_STOP;
								s_d.sdaLow = 1'b1;
							end else begin
								s_d.busState = i2c_abort_pkg::ST_BIT;
								s_d.shift = s_q.txByte;
								s_d.firstByte = 1'b0;
								s_d.bitIdx = 3'h7;
								s_d.sdaLow = !s_q.txByte[7];
							end
						end
					endcase
				end
			end
			i2c_abort_pkg::ST_STOP: begin
				if (tick) begin
					s_d.quarter = s_q.quarter + 2'h1;
					if (s_q.quarter == 2'h0) begin
						s_d.sclLow = 1'b0;
					end else if (s_q.quarter == 2'h1) begin
						s_d.sdaLow = 1'b0;
					end else begin
						s_d.busState = i2c_abort_pkg::ST_IDLE;
						s_d.quarter = 2'h0;
						ev[i2c_abort_pkg::INT_DONE_BIT] = 1'b1;
						ev[i2c_abort_pkg::INT_NACK_BIT] = s_q.nack;
					end
				end
			end
			default: s_d.busState = i2c_abort_pkg::ST_IDLE;
		endcase

		// Sticky interrupt status, set beats clear
		s_d.intStat = (s_q.intStat & ~intClr) | ev;
	end

	always_ff @(posedge sys_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			s_q <= i2c_abort_pkg::STATE_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ---- verification/i2c_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
	// Controller pin enables
	input  wire logic sclOeN,
	input  wire logic sdaOeN,
	// Wire levels
	output logic      sclLine,
	output logic      sdaLine
);
	// Pull-ups only: no target answers, so every address reads as NACK
	assign sclLine = sclOeN ? 1'h1 : 1'h0;
	assign sdaLine = sdaOeN ? 1'h1 : 1'h0;
endmodule
`default_nettype wire

// ---- verification/restart_disabled_abort_flags_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module restart_disabled_abort_flags_properties #(
	parameter int STD_QUARTER = 2,
	parameter int HS_QUARTER  = 1
) (
	// Clock, reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Register bus
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	// Pins, interrupt
	input wire logic        sclOeN,
	input wire logic        sdaOeN,
	input wire logic        irq
);
	typedef struct packed {
		logic [7:0]  awA;
		logic [7:0]  arA;
		logic [31:0] wD;
		logic        rstEn;
		logic        hs;
		logic        cmdSel;
		logic        gc;
		logic        intEn;
		logic        sbExp;
		logic        hsExp;
	} chk_t;
	chk_t q;
	chk_t d;
	logic done;
	logic sbCause;
	logic hsCause;
	logic txCause;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	assign done    = bvalid && bready;
	assign sbCause = !q.rstEn && q.cmdSel && q.gc;
	assign hsCause = !q.rstEn && q.hs;
	assign txCause = done && q.awA == i2c_abort_pkg::TXDATA_OFS && (sbCause || hsCause);
	// Shadow of the software view, updated at write completion
	always_comb begin
		d = q;
		if (awvalid && awready) d.awA = awaddr;
		if (wvalid && wready) d.wD = wdata;
		if (arvalid && arready) d.arA = araddr;
		if (done) begin
			case (q.awA)
				i2c_abort_pkg::CTRL_OFS: begin
					d.rstEn = q.wD[5];
					d.hs = q.wD[2];
				end
				i2c_abort_pkg::TARGET_OFS: begin
					d.cmdSel = q.wD[11];
					d.gc = q.wD[10];
				end
				i2c_abort_pkg::INT_EN_OFS: d.intEn = q.wD[0];
				i2c_abort_pkg::TXDATA_OFS: begin
					d.sbExp = q.sbExp | sbCause;
					d.hsExp = q.hsExp | hsCause;
				end
				i2c_abort_pkg::ABORT_CLR_OFS: if (q.wD[0]) begin
					d.sbExp = q.sbExp & sbCause;
					d.hsExp = q.hsExp & hsCause;
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) q <= '{rstEn: 1'h1, default: '0};
		else q <= d;
	end
	property p_abortMask;
		rvalid && q.arA == i2c_abort_pkg::ABORT_SRC_OFS |-> rdata[31:10] == 22'h0 && rdata[7:0] == 8'h0;
	endproperty
	a_abortMask: assert property (p_abortMask) else $error("abort word shows bits outside the two flags");
	property p_sbyteFlag;
		rvalid && q.arA == i2c_abort_pkg::ABORT_SRC_OFS |-> rdata[9] == q.sbExp;
	endproperty
	a_sbyteFlag: assert property (p_sbyteFlag) else $error("start byte abort flag wrong");
	property p_hsFlag;
		rvalid && q.arA == i2c_abort_pkg::ABORT_SRC_OFS |-> rdata[8] == q.hsExp;
	endproperty
	a_hsFlag: assert property (p_hsFlag) else $error("high speed abort flag wrong");
	property p_noBus;
		txCause |-> (sdaOeN && sclOeN) [*8];
	endproperty
	a_noBus: assert property (p_noBus) else $error("bus driven for aborted command");
	property p_abortIrq;
		txCause && q.intEn |-> ##[1:4] irq;
	endproperty
	a_abortIrq: assert property (p_abortIrq) else $error("no interrupt for aborted command");
	property p_resetQuiet;
		$rose(nrst) |-> !irq && !bvalid && !rvalid;
	endproperty
	a_resetQuiet: assert property (p_resetQuiet) else $error("outputs not idle out of reset");
endmodule
bind restart_disabled_abort_flags restart_disabled_abort_flags_properties #(
	.STD_QUARTER(STD_QUARTER),
	.HS_QUARTER(HS_QUARTER)
) chk_inst (.sys_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bvalid, .bready,
	.araddr, .arvalid, .arready, .rdata, .rvalid, .sclOeN, .sdaOeN, .irq);
`default_nettype wire

// ---- verification/restart_disabled_abort_flags_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module restart_disabled_abort_flags_bench;
	logic        sys_clk = 1'h0;
	logic        nrst = 1'h0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        sclOeN, sdaOeN, sclLine, sdaLine;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp, rsp;
	int          bad_count = 0;
	int          checked = 0;
	restart_disabled_abort_flags #(.STD_QUARTER(2), .HS_QUARTER(1)) restart_disabled_abort_flags_inst (
		.sys_clk, .nrst, .ce(1'h1), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.sclIn(sclLine), .sclOut(), .sclOeN, .sdaIn(sdaLine), .sdaOut(), .sdaOeN, .irq);
	i2c_bus_model i2c_bus_model_inst (.sclOeN, .sdaOeN, .sclLine, .sdaLine);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkBit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 100);
		bready <= 1'h0;
		checkBit(n < 100, 1'h1);
		checkWord({30'h0, bresp}, {30'h0, i2c_abort_pkg::RESP_OKAY});
	endtask
	// Read after a short gap, then compare the word
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		int n;
		n = 0;
		repeat (3) @(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 100);
		rready <= 1'h0;
		rsp = rresp;
		checkWord(rdata, exp);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h0);
		wr(i2c_abort_pkg::INT_EN_OFS, 32'h1);
		wr(i2c_abort_pkg::CTRL_OFS, 32'h1);
		wr(i2c_abort_pkg::TARGET_OFS, 32'hC55);
		wr(i2c_abort_pkg::TXDATA_OFS, 32'h12);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h200);
		checkBit(irq, 1'h1);
		checkBit(sdaOeN, 1'h1);
		wr(i2c_abort_pkg::ABORT_CLR_OFS, 32'h1);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h200);
		wr(i2c_abort_pkg::ABORT_SRC_OFS, 32'h0);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h200);
		wr(i2c_abort_pkg::TARGET_OFS, 32'h455);
		wr(i2c_abort_pkg::ABORT_CLR_OFS, 32'h1);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h0);
		wr(i2c_abort_pkg::TXDATA_OFS, 32'h12);
		repeat (400) @(posedge sys_clk);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h0);
		rdChk(i2c_abort_pkg::INT_STAT_OFS, 32'h7);
		wr(i2c_abort_pkg::INT_CLR_OFS, 32'h7);
		checkBit(irq, 1'h0);
		wr(i2c_abort_pkg::CTRL_OFS, 32'h5);
		wr(i2c_abort_pkg::TXDATA_OFS, 32'h34);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h100);
		checkBit(irq, 1'h1);
		wr(i2c_abort_pkg::CTRL_OFS, 32'h21);
		wr(i2c_abort_pkg::ABORT_CLR_OFS, 32'h1);
		rdChk(i2c_abort_pkg::ABORT_SRC_OFS, 32'h0);
		wr(i2c_abort_pkg::INT_EN_OFS, 32'h0);
		checkBit(irq, 1'h0);
		wr(i2c_abort_pkg::INT_EN_OFS, 32'h1);
		checkBit(irq, 1'h1);
		wr(i2c_abort_pkg::INT_CLR_OFS, 32'h7);
		@(posedge sys_clk);
		checkBit(irq, 1'h0);
		rdChk(8'h40, 32'h0);
		checkWord({30'h0, rsp}, {30'h0, i2c_abort_pkg::RESP_SLVERR});
		summarize();
	end
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
endmodule
`default_nettype wire
